// file: hdl/tcp_pkg.sv
// Purpose: shared constants for the timer channel pwm block
// Assumes: 16-bit counter, 3-bit prescaler select
// Notes:   prescale select n divides the bus clock by 2**n
package tcp_pkg;
  localparam int          CNT_W      = 16;
  localparam int          PS_W       = 3;
  localparam int          PS_DIV_W   = 7;
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [15:0] MOD_RST    = 16'hffff;
  localparam logic [15:0] CH_RST     = 16'h0000;
  localparam logic [2:0]  PS_RST     = 3'h0;
  localparam logic [6:0]  DIV_RST    = 7'h00;
  localparam logic        PWM_ACTIVE = 1'b1;
  localparam logic        PWM_IDLE   = 1'b0;
  localparam logic        FLAG_RST   = 1'b0;
endpackage

// file: hdl/tcp_prescaler.sv
// Purpose: prescaler producing a one-cycle count enable
// Assumes: synchronous active-low reset
// Notes:   select 0 ticks every bus clock
`timescale 1ns/100ps
module tcp_prescaler #(
  parameter int PS_W  = tcp_pkg::PS_W,
  parameter int DIV_W = tcp_pkg::PS_DIV_W
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  // control
  input  wire logic [PS_W-1:0] ps_sel,
  output logic                 tick
);
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic [DIV_W-1:0] mask;

  always_comb begin
    mask    = DIV_W'((1 << ps_sel) - 1);
    div_nxt = DIV_W'(div_r + 1'b1) & mask;
    tick    = ((div_r & mask) == mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_r <= tcp_pkg::DIV_RST;
    end else begin
      div_r <= div_nxt;
    end
  end
endmodule // tcp_prescaler

// file: hdl/tcp_timer_channel_pwm.sv
// Purpose: one output-compare channel of a 16-bit timer in unbuffered pwm mode
// Assumes: modulo, channel value and prescale select are plain inputs, no register bus
// Notes:   channel value takes effect at once, so unsynchronised writes can glitch
//          duty is channel value over modulo plus one; zero gives a low pin,
//          values above modulo give a high pin for the whole period
`timescale 1ns/100ps

module tcp_timer_channel_pwm #(
  parameter int CNT_W = tcp_pkg::CNT_W,
  parameter int PS_W  = tcp_pkg::PS_W
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,

  // enable and prescale
  input  wire logic             pwm_en,
  input  wire logic [PS_W-1:0]  ps_sel,

  // period and compare
  input  wire logic [CNT_W-1:0] modulo,
  input  wire logic [CNT_W-1:0] ch_value,

  // flag control
  input  wire logic             ovf_clr,

  // counter and flags
  output logic [CNT_W-1:0]      count,
  output logic                  ovf_flag,
  output logic                  ovf_pulse,
  output logic                  match_pulse,

  // pin
  output logic                  pwm_out
);
  // prescaled count enable
  logic             tick;
  // event decode
  logic             run_tick;
  logic             top_hit;
  logic             next_eq;
  logic             wrap;
  logic             hit;
  // counter
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  // sticky overflow flag
  logic             ovf_r;
  logic             ovf_nxt;
  // overflow pulse
  logic             ovp_r;
  logic             ovp_nxt;
  // match pulse
  logic             mtp_r;
  logic             mtp_nxt;
  // output pin
  logic             pin_r;
  logic             pin_nxt;

  // next count value, wrapping at the counter width
  function automatic logic [CNT_W-1:0] cnt_inc(
    input logic [CNT_W-1:0] cur
  );
    return CNT_W'(cur + 1'b1);
  endfunction

  // greater-or-equal so a modulo lowered below the count still ends the period
  function automatic logic at_top(
    input logic [CNT_W-1:0] cur,
    input logic [CNT_W-1:0] top
  );
    return (cur >= top);
  endfunction

  // compare with the count about to be taken: the pin is low from the count
  // equal to the channel value on, so the duty is value over period
  function automatic logic cmp_next(
    input logic [CNT_W-1:0] cur,
    input logic [CNT_W-1:0] val
  );
    return (cnt_inc(cur) == val);
  endfunction

  // level at the start of a period; zero gives zero duty since its match
  // would fall on the overflow itself
  function automatic logic wrap_level(
    input logic [CNT_W-1:0] val
  );
    return (val == CNT_W'(tcp_pkg::CH_RST)) ? tcp_pkg::PWM_IDLE : tcp_pkg::PWM_ACTIVE;
  endfunction

  // set wins over a clear in the same cycle, so no overflow is ever lost
  function automatic logic flag_next(
    input logic cur,
    input logic do_set,
    input logic do_clr
  );
    return do_set ? 1'b1 : (do_clr ? tcp_pkg::FLAG_RST : cur);
  endfunction

  // the divider runs on while disabled, so the first tick after enable may come early
  tcp_prescaler #(
    .PS_W  (PS_W),
    .DIV_W (tcp_pkg::PS_DIV_W)
  ) u_ps (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ps_sel  (ps_sel),
    .tick    (tick)
  );

  // modulo and channel value act at once: writes not aligned to the counter
  // may upset the one period in which they land
  always_comb begin
    run_tick = pwm_en && tick;
    top_hit  = at_top(cnt_r, modulo);
    next_eq  = cmp_next(cnt_r, ch_value);
    wrap     = run_tick && top_hit;
    // equality only: a value the counter has already passed is simply missed
    hit      = run_tick && !wrap && next_eq;
  end

  // counter; reset and disable both park it at zero
  always_comb begin
    cnt_nxt = cnt_r;
    if (!pwm_en) begin
      cnt_nxt = CNT_W'(tcp_pkg::CNT_RST);
    end else if (wrap) begin
      cnt_nxt = CNT_W'(tcp_pkg::CNT_RST);
    end else if (tick) begin
      cnt_nxt = cnt_inc(cnt_r);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r <= CNT_W'(tcp_pkg::CNT_RST);
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // overflow flag; a clear without a new overflow lowers it
  always_comb begin
    ovf_nxt = flag_next(ovf_r, wrap, ovf_clr);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ovf_r <= tcp_pkg::FLAG_RST;
    end else begin
      ovf_r <= ovf_nxt;
    end
  end

  // overflow pulse, one cycle after the wrap
  always_comb begin
    ovp_nxt = wrap;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ovp_r <= tcp_pkg::FLAG_RST;
    end else begin
      ovp_r <= ovp_nxt;
    end
  end

  // match pulse, in the cycle the counter holds the channel value
  always_comb begin
    mtp_nxt = hit;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mtp_r <= tcp_pkg::FLAG_RST;
    end else begin
      mtp_r <= mtp_nxt;
    end
  end

  // output pin; low until the first overflow after reset or enable
  // a channel value above modulo never matches, so the pin then stays high
  always_comb begin
    pin_nxt = pin_r;
    if (!pwm_en) begin
      pin_nxt = tcp_pkg::PWM_IDLE;
    end else if (wrap) begin
      pin_nxt = wrap_level(ch_value);
    end else if (hit) begin
      pin_nxt = tcp_pkg::PWM_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_r <= tcp_pkg::PWM_IDLE;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  // outputs straight from the registers
  assign count       = cnt_r;
  assign ovf_flag    = ovf_r;
  assign ovf_pulse   = ovp_r;
  assign match_pulse = mtp_r;
  assign pwm_out     = pin_r;
endmodule // tcp_timer_channel_pwm

// file: tb/tcp_pwm_sva.sv
// Purpose: port checks for the pwm channel
// Assumes: exact step checks only with ps_sel 0
// Notes: bound after the module
`timescale 1ns/100ps
module tcp_pwm_sva (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // controls
  input wire logic        pwm_en,
  input wire logic        ovf_clr,
  input wire logic [2:0]  ps_sel,
  input wire logic [15:0] modulo,
  input wire logic [15:0] ch_value,
  // outputs
  input wire logic [15:0] count,
  input wire logic        ovf_flag,
  input wire logic        ovf_pulse,
  input wire logic        match_pulse,
  input wire logic        pwm_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire t0 = pwm_en && ps_sel == 3'h0;
  property p_wrap; t0 && count >= modulo |=> count == 16'h0000 && ovf_pulse; endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");
  property p_inc; t0 && count < modulo |=> count == $past(count) + 16'h0001; endproperty
  a_inc: assert property (p_inc) else $error("counter did not step");
  property p_ovf; ovf_pulse |-> ovf_flag; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set");
  property p_hi; ovf_pulse && $past(ch_value) != 16'h0000 |-> pwm_out; endproperty
  a_hi: assert property (p_hi) else $error("pin not active at wrap");
  property p_match; t0 && 16'(count + 16'h0001) == ch_value && count < modulo |=> match_pulse && !pwm_out; endproperty
  a_match: assert property (p_match) else $error("compare missed");
  property p_cause; match_pulse |-> count == $past(ch_value); endproperty
  a_cause: assert property (p_cause) else $error("match without equality");
  property p_rise; $rose(pwm_out) |-> ovf_pulse; endproperty
  a_rise: assert property (p_rise) else $error("pin rose off wrap");
  property p_fall; $fell(pwm_out) |-> match_pulse || ovf_pulse || !$past(pwm_en); endproperty
  a_fall: assert property (p_fall) else $error("pin fell off match");
  property p_off; !$past(pwm_en) |-> count == 16'h0000 && !pwm_out && !ovf_pulse && !match_pulse; endproperty
  a_off: assert property (p_off) else $error("disabled channel not idle");
  c_match: cover property (match_pulse);
  c_wrap: cover property (ovf_pulse && pwm_out);
  c_fall: cover property ($fell(pwm_out));
endmodule // tcp_pwm_sva
bind tcp_timer_channel_pwm tcp_pwm_sva i_sva (.ref_clk, .rst_n, .pwm_en, .ovf_clr, .ovf_flag, .ovf_pulse,
  .match_pulse, .pwm_out, .ps_sel, .modulo, .ch_value, .count);

// file: tb/timer_channel_pwm_tb.sv
// Purpose: random and corner pwm runs
// Assumes: ps_sel up to 2 keeps random runs short; the corner runs take ps_sel 0 and 1, the modulo 5 sweep ps_sel 3 to 7
// Notes: inputs move on the falling edge
`timescale 1ns/100ps
module timer_channel_pwm_tb;
  logic        ref_clk = 0, rst_n = 0, pwm_en = 0, ovf_clr = 0, ovf_flag, ovf_pulse, match_pulse, pwm_out;
  logic [2:0]  ps_sel = 3'h0;
  logic [15:0] modulo = 16'h00ff, ch_value = 16'h0000, count;
  int          error_cnt = 0, checks_done = 0, hi, per, mp, i;
  always #10 ref_clk = ~ref_clk;
  tcp_timer_channel_pwm i_dut (.ref_clk, .rst_n, .pwm_en, .ps_sel, .modulo, .ch_value, .ovf_clr,
    .count, .ovf_flag, .ovf_pulse, .match_pulse, .pwm_out);
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // counts cycles up to the next wrap; a hang ends the run
  task automatic nxt_ovf;
    per = 0; hi = 0; mp = 0;
    do begin
      @(negedge ref_clk);
      per++; hi += pwm_out; mp += match_pulse;
    end while (ovf_pulse !== 1'b1 && per < 3000);
    if (per >= 3000) begin chk(1'b0, "timeout"); test_done; end
  endtask
  function automatic int e_hi(int m, int c, int p); return (c > m ? m + 1 : c) << p; endfunction
  function automatic int e_mp(int m, int c); return (c >= 1 && c <= m) ? 1 : 0; endfunction
  task automatic wait_cnt(input logic [15:0] v);
    i = 0;
    while (count !== v && i < 100) begin @(negedge ref_clk); i++; end
    if (i >= 100) begin chk(1'b0, "wait ran out"); test_done; end
  endtask
  task automatic run(input int m, c, p);
    @(negedge ref_clk);
    modulo = m[15:0]; ch_value = c[15:0]; ps_sel = p[2:0];
    nxt_ovf; nxt_ovf; nxt_ovf;
    chk(per == ((m + 1) << p), "period");
    chk(hi == e_hi(m, c, p), "width");
    chk(mp == e_mp(m, c), "match count");
    chk(count === 16'h0000, "count at wrap");
  endtask
  initial begin
    void'($urandom(28));
    repeat (6) @(negedge ref_clk);
    rst_n = 1;
    pwm_en = 1;
    run(255, 128, 0);
    run(9, 0, 0);
    run(9, 12, 1);
    for (i = 0; i < 6; i++) run($urandom_range(30, 1), $urandom_range(31, 0), $urandom_range(2, 0));
    for (i = 3; i < 8; i++) run(5, 3, i);
    run(40, 30, 0);
    wait_cnt(16'h0014);
    ch_value = 16'h000a; // late write below the count
    nxt_ovf;
    chk(mp == 0, "no match expected");
    chk(hi == per, "pin stays active");
    chk(ovf_flag === 1'b1, "flag set");
    ovf_clr = 1;
    @(negedge ref_clk);
    ovf_clr = 0;
    chk(ovf_flag === 1'b0, "flag clear");
    wait_cnt(16'h0028);
    ovf_clr = 1;
    @(negedge ref_clk);
    ovf_clr = 0;
    chk(ovf_flag === 1'b1, "set wins over clear");
    repeat (2) @(negedge ref_clk);
    pwm_en = 0;
    @(negedge ref_clk);
    chk(count === 16'h0000 && pwm_out === 1'b0, "disabled output idle");
    test_done;
  end
endmodule // timer_channel_pwm_tb
